// ===== logic/pieb_defines.vh
// Register map, field positions and reset values of the peripheral
// interrupt enable bank.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
`ifndef PIEB_DEFINES_VH
`define PIEB_DEFINES_VH

`define PIEB_ADDR_W 6
`define PIEB_OFS_LCTG 6'h00
`define PIEB_OFS_CCMP 6'h04
`define PIEB_OFS_GCTL 6'h08
`define PIEB_OFS_PEND 6'h0C
`define PIEB_OFS_STAT 6'h10
`define PIEB_OFS_MASK 6'h14

`define PIEB_LCTG_MASK 8'hF7
`define PIEB_CCMP_MASK 8'h1F
`define PIEB_LCTG_RST 8'h00
`define PIEB_CCMP_RST 8'h00
`define PIEB_GCTL_RST 1'b0
`define PIEB_STAT_W 2
`define PIEB_STAT_RST 2'h0
`define PIEB_MASK_RST 2'h0

`define PIEB_RESP_OKAY 2'h0
`define PIEB_RESP_SLVERR 2'h2

`endif

// ===== logic/pieb_top.v
// Peripheral interrupt enable bank with an AXI4-Lite register slave.
// Assumes request inputs are asynchronous pins from peripherals; they are
// synchronised here. One clock, asynchronous active-low reset.
// Operation
// - Enable bits 7 to 4 of the first register gate logic cells 4 to 1.
// - Enable bits 2 to 0 of the first register gate timer 5, 3, 1 gates.
// - Enable bits 4 to 0 of the second register gate capture units 5 to 1.
// - Unimplemented bits read as zero and ignore writes.
// - Every implemented enable bit is read/write and clears on any reset.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`include "pieb_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pieb_top (
  input wire ref_clk_i, // System clock, 200 MHz.
  input wire rst_n_i, // Asynchronous reset, active low.
  input wire [3:0] logic_cell_irq_req_i, // Logic cell 4..1 requests.
  input wire [2:0] timer_gate_irq_req_i, // Timer 5,3,1 gate requests.
  input wire [4:0] capcmp_irq_req_i, // Capture unit 5..1 requests.
  output reg [11:0] periph_irq_o, // Gated requests to the core.
  output reg periph_irq_any_o, // Any gated request pending.
  output wire irq_o, // Bank event interrupt, level.
  input wire [`PIEB_ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire s_axi_awvalid, // Write address valid.
  output wire s_axi_awready, // Write address ready.
  input wire [31:0] s_axi_wdata, // Write data.
  input wire [3:0] s_axi_wstrb, // Write byte strobes.
  input wire s_axi_wvalid, // Write data valid.
  output wire s_axi_wready, // Write data ready.
  output reg [1:0] s_axi_bresp, // Write response.
  output reg s_axi_bvalid, // Write response valid.
  input wire s_axi_bready, // Write response ready.
  input wire [`PIEB_ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire s_axi_arvalid, // Read address valid.
  output wire s_axi_arready, // Read address ready.
  output reg [31:0] s_axi_rdata, // Read data.
  output reg [1:0] s_axi_rresp, // Read response.
  output reg s_axi_rvalid, // Read data valid.
  input wire s_axi_rready // Read data ready.
);

  reg [7:0] lctg_en_ff;
  reg [7:0] ccmp_en_ff;
  reg peripheral_irq_global_en_ff;
  reg [`PIEB_STAT_W-1:0] stat_ff;
  reg [`PIEB_STAT_W-1:0] mask_ff;
  reg [11:0] req_s1_ff;
  reg [11:0] req_s2_ff;
  reg [11:0] req_prev_ff;
  reg aw_held_ff;
  reg w_held_ff;
  reg [`PIEB_ADDR_W-1:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  // Named enable bits of both enable registers.
  wire logic_cell4_irq_en;
  wire logic_cell3_irq_en;
  wire logic_cell2_irq_en;
  wire logic_cell1_irq_en;
  wire timer5_gate_irq_en;
  wire timer3_gate_irq_en;
  wire timer1_gate_irq_en;
  wire capcmp5_irq_en;
  wire capcmp4_irq_en;
  wire capcmp3_irq_en;
  wire capcmp2_irq_en;
  wire capcmp1_irq_en;

  wire [11:0] req_raw;
  wire [11:0] en_vec;
  wire [11:0] req_rise;
  wire [11:0] nxt_periph_irq;
  wire blocked_evt;
  wire gated_evt;
  wire [`PIEB_STAT_W-1:0] stat_evt;
  wire do_write;
  wire wr_lane0;
  wire [`PIEB_ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire wr_hit;
  reg [31:0] nxt_rdata;
  reg nxt_rerr;

  // Word-address compare used by both bus channels.
  function hit;
    input [`PIEB_ADDR_W-1:0] a;
    input [`PIEB_ADDR_W-1:0] ofs;
    begin
      hit = (a[`PIEB_ADDR_W-1:2] == ofs[`PIEB_ADDR_W-1:2]);
    end
  endfunction

  // True when the address selects one of the six mapped words.
  function mapped;
    input [`PIEB_ADDR_W-1:0] a;
    begin
      mapped = hit(a, `PIEB_OFS_LCTG) ||
               hit(a, `PIEB_OFS_CCMP) ||
               hit(a, `PIEB_OFS_GCTL) ||
               hit(a, `PIEB_OFS_PEND) ||
               hit(a, `PIEB_OFS_STAT) ||
               hit(a, `PIEB_OFS_MASK);
    end
  endfunction

  assign logic_cell4_irq_en = lctg_en_ff[7];
  assign logic_cell3_irq_en = lctg_en_ff[6];
  assign logic_cell2_irq_en = lctg_en_ff[5];
  assign logic_cell1_irq_en = lctg_en_ff[4];
  assign timer5_gate_irq_en = lctg_en_ff[2];
  assign timer3_gate_irq_en = lctg_en_ff[1];
  assign timer1_gate_irq_en = lctg_en_ff[0];
  assign capcmp5_irq_en = ccmp_en_ff[4];
  assign capcmp4_irq_en = ccmp_en_ff[3];
  assign capcmp3_irq_en = ccmp_en_ff[2];
  assign capcmp2_irq_en = ccmp_en_ff[1];
  assign capcmp1_irq_en = ccmp_en_ff[0];

  assign req_raw = {capcmp_irq_req_i, timer_gate_irq_req_i,
                    logic_cell_irq_req_i};
  // Enable vector in the same order as req_raw.
  assign en_vec = {capcmp5_irq_en, capcmp4_irq_en, capcmp3_irq_en,
                   capcmp2_irq_en, capcmp1_irq_en,
                   timer5_gate_irq_en, timer3_gate_irq_en,
                   timer1_gate_irq_en,
                   logic_cell4_irq_en, logic_cell3_irq_en,
                   logic_cell2_irq_en, logic_cell1_irq_en};
  assign nxt_periph_irq = req_s2_ff & en_vec &
                          {12{peripheral_irq_global_en_ff}};

  // Status events: a new request arrived while blocked, or was forwarded.
  assign req_rise = req_s2_ff & ~req_prev_ff;
  assign blocked_evt = |(req_rise & ~nxt_periph_irq);
  assign gated_evt = |(req_rise & nxt_periph_irq);
  assign stat_evt = {gated_evt, blocked_evt};
  assign irq_o = |(stat_ff & mask_ff);

  // Two-flop synchroniser of the asynchronous request pins.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_s1_ff <= 12'h000;
      req_s2_ff <= 12'h000;
      req_prev_ff <= 12'h000;
    end else begin
      req_s1_ff <= req_raw;
      req_s2_ff <= req_s1_ff;
      req_prev_ff <= req_s2_ff;
    end
  end

  // Gated requests towards the core leave from flip-flops.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      periph_irq_o <= 12'h000;
      periph_irq_any_o <= 1'b0;
    end else begin
      periph_irq_o <= nxt_periph_irq;
      periph_irq_any_o <= |nxt_periph_irq;
    end
  end

  // Write channel: address and data accepted in either order.
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
  assign do_write = (aw_held_ff || (s_axi_awvalid && s_axi_awready)) &&
                    (w_held_ff || (s_axi_wvalid && s_axi_wready));
  assign wr_hit = mapped(wr_addr);
  assign wr_lane0 = do_write && wr_strb[0];

  // Address holder: keeps an early address until its data arrives.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= {`PIEB_ADDR_W{1'b0}};
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
  end

  // Data holder: keeps early data until its address arrives.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
  end

  // Write response, raised the cycle after both halves are in.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PIEB_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `PIEB_RESP_OKAY : `PIEB_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register file; only byte lane 0 carries implemented bits.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lctg_en_ff <= `PIEB_LCTG_RST;
    end else if (wr_lane0 && hit(wr_addr, `PIEB_OFS_LCTG)) begin
      lctg_en_ff <= wr_data[7:0] & `PIEB_LCTG_MASK;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ccmp_en_ff <= `PIEB_CCMP_RST;
    end else if (wr_lane0 && hit(wr_addr, `PIEB_OFS_CCMP)) begin
      ccmp_en_ff <= wr_data[7:0] & `PIEB_CCMP_MASK;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      peripheral_irq_global_en_ff <= `PIEB_GCTL_RST;
    end else if (wr_lane0 && hit(wr_addr, `PIEB_OFS_GCTL)) begin
      peripheral_irq_global_en_ff <= wr_data[0];
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_ff <= `PIEB_MASK_RST;
    end else if (wr_lane0 && hit(wr_addr, `PIEB_OFS_MASK)) begin
      mask_ff <= wr_data[`PIEB_STAT_W-1:0];
    end
  end

  // Write-one-to-clear; a same-cycle event keeps its bit set.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_ff <= `PIEB_STAT_RST;
    end else if (wr_lane0 && hit(wr_addr, `PIEB_OFS_STAT)) begin
      stat_ff <= (stat_ff & ~wr_data[`PIEB_STAT_W-1:0]) | stat_evt;
    end else begin
      stat_ff <= stat_ff | stat_evt;
    end
  end

  // Read channel: one read at a time, answered the cycle after acceptance.
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_rerr = 1'b0;
    if (hit(s_axi_araddr, `PIEB_OFS_LCTG)) begin
      nxt_rdata[7:0] = lctg_en_ff & `PIEB_LCTG_MASK;
    end else if (hit(s_axi_araddr, `PIEB_OFS_CCMP)) begin
      nxt_rdata[7:0] = ccmp_en_ff & `PIEB_CCMP_MASK;
    end else if (hit(s_axi_araddr, `PIEB_OFS_GCTL)) begin
      nxt_rdata[0] = peripheral_irq_global_en_ff;
    end else if (hit(s_axi_araddr, `PIEB_OFS_PEND)) begin
      nxt_rdata[11:0] = req_s2_ff;
    end else if (hit(s_axi_araddr, `PIEB_OFS_STAT)) begin
      nxt_rdata[`PIEB_STAT_W-1:0] = stat_ff;
    end else if (hit(s_axi_araddr, `PIEB_OFS_MASK)) begin
      nxt_rdata[`PIEB_STAT_W-1:0] = mask_ff;
    end else begin
      nxt_rerr = 1'b1;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PIEB_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= nxt_rerr ? `PIEB_RESP_SLVERR : `PIEB_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ===== tb/pieb_assertions.sv
// Checker of the enable bank's register bus and request gating.
// Assumes it is bound to pieb_top, one clock, active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pieb_chk (
  input wire logic ref_clk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic [3:0] logic_cell_irq_req_i, // Cell requests.
  input wire logic [2:0] timer_gate_irq_req_i, // Timer requests.
  input wire logic [4:0] capcmp_irq_req_i, // Capture requests.
  input wire logic [11:0] periph_irq_o, // Gated requests.
  input wire logic periph_irq_any_o, // Any gated request.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic [5:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic s_axi_rvalid // Read data valid.
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [5:0] rd_addr_ff;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i) rd_addr_ff <= 6'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_ff <= s_axi_araddr;
  a_cell_gating: assert property (
    (periph_irq_o[3:0] & ~$past(logic_cell_irq_req_i, 3)) == 4'h0)
    else $error("cell output without request");
  a_timer_gating: assert property (
    (periph_irq_o[6:4] & ~$past(timer_gate_irq_req_i, 3)) == 3'h0)
    else $error("timer output without request");
  a_capcmp_gating: assert property (
    (periph_irq_o[11:7] & ~$past(capcmp_irq_req_i, 3)) == 5'h00)
    else $error("capture output without request");
  a_unimpl_zero: assert property (
    s_axi_rvalid |-> (rd_addr_ff != 6'h00 || s_axi_rdata[31:8] == 24'h0
    && !s_axi_rdata[3]) &&
    (rd_addr_ff != 6'h04 || s_axi_rdata[31:5] == 27'h0))
    else $error("unimplemented bit read as one");
  a_reset_clear: assert property (
    $rose(rst_n_i) |-> periph_irq_o == 12'h000 && !s_axi_bvalid &&
    !s_axi_rvalid)
    else $error("outputs not clear after reset");
  a_any_gated: assert property (
    periph_irq_any_o == (|periph_irq_o))
    else $error("any flag disagrees with outputs");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read not answered");
endmodule
bind pieb_top pieb_chk u_chk (.*);
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the enable bank through its register bus.
// Assumes reads answer one cycle after the address is taken.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, periph_irq_any_o, irq_o;
  logic [3:0] logic_cell_irq_req_i, s_axi_wstrb;
  logic [2:0] timer_gate_irq_req_i;
  logic [4:0] capcmp_irq_req_i;
  logic [11:0] periph_irq_o, e;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, lc, cc, g;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$];
  int error_cnt = 0, n_tests = 0, cyc = 0, seed = 32'h526a;
  pieb_top dut (.*);
  initial begin
    ref_clk_i = 1'h0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task finish_test();
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cmp_rd(input [33:0] x, input [33:0] a);
    n_tests++;
    if (a !== x) begin
      error_cnt++;
      $display("[FAIL] %0t read %h want %h", $time, a, x);
    end
  endtask
  task cmp_wr(input [1:0] x, input [1:0] a);
    n_tests++;
    if (a !== x) begin
      error_cnt++;
      $display("[FAIL] %0t write response %h want %h", $time, a, x);
    end
  endtask
  task cmp_out(input [11:0] x, input [11:0] a);
    n_tests++;
    if (a !== x) begin
      error_cnt++;
      $display("[FAIL] %0t output %h want %h", $time, a, x);
    end
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
    if (s_axi_rvalid && s_axi_rready)
      cmp_rd(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      cmp_wr(exp_q.pop_front() >> 32, s_axi_bresp);
  end
  task wr(input [5:0] a, input [31:0] d);
    @(posedge ref_clk_i);
    exp_q.push_back({(a >= 6'h18) ? 2'h2 : 2'h0, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task rd(input [5:0] a, input [33:0] x);
    @(posedge ref_clk_i);
    exp_q.push_back(x);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     capcmp_irq_req_i, timer_gate_irq_req_i, logic_cell_irq_req_i,
     s_axi_awaddr, s_axi_araddr, s_axi_wdata, rst_n_i} = '0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    rd(6'h00, 34'h0);
    rd(6'h04, 34'h0);
    for (int i = 0; i < 8; i++) begin
      lc = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      cc = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      g = (i == 7) ? 32'h0 : 32'h1;
      wr(6'h00, lc);
      wr(6'h04, cc);
      wr(6'h08, g);
      rd(6'h00, {26'h0, lc[7:0] & 8'hF7});
      rd(6'h04, {29'h0, cc[4:0]});
      @(posedge ref_clk_i);
      {capcmp_irq_req_i, timer_gate_irq_req_i, logic_cell_irq_req_i} <=
        12'($random(seed));
      repeat (4) @(posedge ref_clk_i);
      e = {cc[4:0] & capcmp_irq_req_i, lc[2:0] & timer_gate_irq_req_i,
           lc[7:4] & logic_cell_irq_req_i} & {12{g[0]}};
      cmp_out(e, periph_irq_o);
      cmp_out({11'h0, |e}, {11'h0, periph_irq_any_o});
    end
    rd(6'h18, {2'h2, 32'h0});
    wr(6'h18, 32'h1);
    {capcmp_irq_req_i, timer_gate_irq_req_i, logic_cell_irq_req_i} <= 12'h000;
    repeat (4) @(posedge ref_clk_i);
    wr(6'h10, 32'h3);
    wr(6'h14, 32'h0);
    wr(6'h00, 32'h0);
    @(posedge ref_clk_i);
    logic_cell_irq_req_i <= 4'h1;
    repeat (6) @(posedge ref_clk_i);
    cmp_out(12'h0, {11'h0, irq_o});
    rd(6'h10, 34'h1);
    wr(6'h14, 32'h3);
    @(posedge ref_clk_i);
    cmp_out(12'h1, {11'h0, irq_o});
    wr(6'h10, 32'h1);
    @(posedge ref_clk_i);
    cmp_out(12'h0, {11'h0, irq_o});
    logic_cell_irq_req_i <= 4'h0;
    repeat (4) @(posedge ref_clk_i);
    wr(6'h08, 32'h1);
    wr(6'h00, 32'h10);
    logic_cell_irq_req_i <= 4'h1;
    repeat (6) @(posedge ref_clk_i);
    cmp_out(12'h001, periph_irq_o);
    cmp_out(12'h1, {11'h0, irq_o});
    rd(6'h10, 34'h2);
    wr(6'h04, 32'h1F);
    @(posedge ref_clk_i);
    rst_n_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    rd(6'h04, 34'h0);
    rd(6'h08, 34'h0);
    finish_test();
  end
endmodule
`default_nettype wire
